// file: logic/sar_adc_control.sv
`timescale 1ns/10ps
`default_nettype none
module sar_adc_control (
   input  wire logic                 hclk,
   input  wire logic                 hresetn,
   input  wire logic                 ce,
   input  wire logic                 hsel,
   input  wire logic [31:0]          haddr,
   input  wire logic [1:0]           htrans,
   input  wire logic                 hwrite,
   input  wire logic [2:0]           hsize,
   input  wire logic [31:0]          hwdata,
   input  wire logic                 hready,
   output logic                      hreadyout,
   output logic                      hresp,
   output logic [31:0]               hrdata,
   input  wire logic                 sleep_mode,
   input  wire logic                 global_irq_enable,
   input  wire logic                 timer_clock_select,
   input  wire logic                 ring_osc_in,
   input  wire logic                 comparator_in,
   output logic [3:0]                analog_pin_enable,
   output logic                      reference_source_select,
   output logic                      pin_ref_function,
   output logic                      pin_timer_function,
   output logic                      pin_port_function,
   output logic                      converter_power_on,
   output logic [1:0]                channel_select,
   output sar_adc_pkg::rate_t        conv_clock_rate,
   output logic                      sample_hold,
   output logic [11:0]               dac_code,
   output logic                      wake_request,
   output logic                      conversion_irq,
   output logic                      irq_vector_jump,
   output logic [11:0]               irq_vector
);
   import sar_adc_pkg::*;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // prescaled clock ticks making one bit period of about 4 us; a single tick, 2.56 us, at divide by 64
   function automatic logic [6:0] ticks_per_bit(input logic [6:0] div);
      logic [6:0] t;
      t = 7'(BIT_CYCLES / int'(div));
      if (t == 7'h0) begin
         t = 7'h1;
      end
      return t;
   endfunction

   // offset correction, saturating at both ends
   function automatic logic [11:0] apply_offset(input logic [11:0] raw,
                                                input logic        en,
                                                input logic        pos,
                                                input logic [2:0]  mag);
      logic [12:0] step;
      logic [12:0] sum;
      step = {9'h0, mag, 1'b0};
      sum  = {1'b0, raw};
      if (!en) begin
         return raw;
      end
      if (pos) begin
         sum = sum + step;
         return sum[12] ? 12'hfff : sum[11:0];
      end
      return (step > sum) ? 12'h000 : 12'(sum - step);
   endfunction

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic [3:0]  in_sel_q, in_sel_d;
   logic        ref_q, ref_d;
   rate_t       rate_q, rate_d;
   logic        run_q, run_d;
   logic        pwr_q, pwr_d;
   logic [1:0]  ch_q, ch_d;
   logic        cal_en_q, cal_en_d;
   logic        cal_pos_q, cal_pos_d;
   logic [2:0]  cal_mag_q, cal_mag_d;
   logic        done_q, done_d;
   logic        wake_en_q, wake_en_d;
   logic        irq_en_q, irq_en_d;
   logic [7:0]  res_byte_q, res_byte_d;
   logic [7:0]  res_hi_q, res_hi_d;
   logic [7:0]  res_lo_q, res_lo_d;
   logic        wake_q, wake_d;
   logic        ap_wr_q, ap_wr_d;
   logic        rd_pend_q, rd_pend_d;
   logic [7:0]  ap_addr_q, ap_addr_d;
   logic [31:0] hrdata_q, hrdata_d;
   logic        ring_meta_q, ring_sync_q, ring_prev_q;
   logic        comp_meta_q, comp_sync_q;
   logic [6:0]  pre_cnt_q, pre_cnt_d;
   logic [6:0]  tick_cnt_q, tick_cnt_d;
   logic        ap_take;
   logic        start;
   logic        abort;
   logic        bit_tick;
   logic        ring_edge;
   logic        eng_busy;
   logic        eng_done;
   logic [11:0] eng_result;
   logic [11:0] corrected;
   logic [6:0]  div;
   logic [31:0] rd_mux;
   logic [7:0]  wbyte;

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   // ring oscillator and comparator come from outside this clock
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ring_meta_q <= 1'b0;
         ring_sync_q <= 1'b0;
         ring_prev_q <= 1'b0;
         comp_meta_q <= 1'b0;
         comp_sync_q <= 1'b0;
      end else if (ce) begin
         ring_meta_q <= ring_osc_in;
         ring_sync_q <= ring_meta_q;
         ring_prev_q <= ring_sync_q;
         comp_meta_q <= comparator_in;
         comp_sync_q <= comp_meta_q;
      end
   end

   assign ring_edge = ring_sync_q & ~ring_prev_q;

   // ----------------------------------------------------------------
   // conversion clock
   // ----------------------------------------------------------------
   // divider select per rate field
   always_comb begin
      case (rate_q)
         RATE_DIV16: div = DIV_BY_16;
         RATE_DIV4:  div = DIV_BY_4;
         RATE_DIV64: div = DIV_BY_64;
         default:    div = DIV_BY_16;
      endcase
   end

   // prescaler and bit-period counter, restarted with each conversion
   always_comb begin
      pre_cnt_d  = pre_cnt_q;
      tick_cnt_d = tick_cnt_q;
      bit_tick   = 1'b0;
      if (start || !eng_busy) begin
         pre_cnt_d  = 7'h0;
         tick_cnt_d = 7'h0;
      end else if (rate_q == RATE_RING) begin
         bit_tick = ring_edge;
      end else if (pre_cnt_q == div - 7'h1) begin
         pre_cnt_d = 7'h0;
         if (tick_cnt_q == ticks_per_bit(div) - 7'h1) begin
            tick_cnt_d = 7'h0;
            bit_tick   = 1'b1;
         end else begin
            tick_cnt_d = tick_cnt_q + 7'h1;
         end
      end else begin
         pre_cnt_d = pre_cnt_q + 7'h1;
      end
   end

   // prescaler registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pre_cnt_q  <= 7'h0;
         tick_cnt_q <= 7'h0;
      end else if (ce) begin
         pre_cnt_q  <= pre_cnt_d;
         tick_cnt_q <= tick_cnt_d;
      end
   end

   // ----------------------------------------------------------------
   // successive approximation core
   // ----------------------------------------------------------------
   sar_engine u_engine (
      .hclk       (hclk),
      .hresetn    (hresetn),
      .ce         (ce),
      .start      (start),
      .abort      (abort),
      .bit_tick   (bit_tick),
      .comp_above (comp_sync_q),
      .busy       (eng_busy),
      .sampling   (sample_hold),
      .done       (eng_done),
      .result     (eng_result),
      .dac_code   (dac_code)
   );

   assign corrected = apply_offset(eng_result, cal_en_q,
                                   cal_pos_q, cal_mag_q);
   assign abort     = eng_busy & ~pwr_q;

   // ----------------------------------------------------------------
   // bus slave
   // ----------------------------------------------------------------
   assign ap_take = hsel & hready & (htrans == HTRANS_NONSEQ) & (hsize == HSIZE_WORD);
   assign wbyte   = hwdata[7:0];

   // register read mux
   always_comb begin
      rd_mux = '0;
      case (ap_addr_q)
         OFS_INPUT_SELECT: rd_mux[SEL_PINS_HI:0] = in_sel_q;
         OFS_CONTROL: begin
            rd_mux[CTL_REF_BIT]           = ref_q;
            rd_mux[CTL_RATE_HI:CTL_RATE_LO] = rate_q;
            rd_mux[CTL_RUN_BIT]           = run_q;
            rd_mux[CTL_PWR_BIT]           = pwr_q;
            rd_mux[CTL_CH_HI:CTL_CH_LO]   = ch_q;
         end
         OFS_OFFSET_CAL: begin
            rd_mux[CAL_EN_BIT]            = cal_en_q;
            rd_mux[CAL_POS_BIT]           = cal_pos_q;
            rd_mux[CAL_MAG_HI:CAL_MAG_LO] = cal_mag_q;
         end
         OFS_RESULT_BYTE: rd_mux[7:0] = res_byte_q;
         OFS_RESULT_HIGH: rd_mux[7:0] = res_hi_q;
         OFS_RESULT_LOW:  rd_mux[7:0] = res_lo_q;
         OFS_STATUS: begin
            rd_mux[ST_DONE_BIT] = done_q;
            rd_mux[ST_WAKE_BIT] = wake_en_q;
         end
         OFS_IRQ_MASK: rd_mux[MASK_IRQ_BIT] = irq_en_q;
         default: rd_mux = '0;
      endcase
   end

   // address phase capture; reads take one wait state
   always_comb begin
      ap_wr_d   = 1'b0;
      rd_pend_d = 1'b0;
      ap_addr_d = ap_addr_q;
      hrdata_d  = hrdata_q;
      if (rd_pend_q) begin
         hrdata_d = rd_mux;
      end
      if (ap_take) begin
         ap_addr_d = haddr[7:0];
         ap_wr_d   = hwrite;
         rd_pend_d = ~hwrite;
      end
   end

   // bus registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap_wr_q   <= 1'b0;
         rd_pend_q <= 1'b0;
         ap_addr_q <= 8'h00;
         hrdata_q  <= '0;
      end else if (ce) begin
         ap_wr_q   <= ap_wr_d;
         rd_pend_q <= rd_pend_d;
         ap_addr_q <= ap_addr_d;
         hrdata_q  <= hrdata_d;
      end
   end

   assign hreadyout = ~rd_pend_q;
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_q;

   // ----------------------------------------------------------------
   // control registers
   // ----------------------------------------------------------------
   assign start = ap_wr_q && (ap_addr_q == OFS_CONTROL) && wbyte[CTL_RUN_BIT]
                  && !run_q && wbyte[CTL_PWR_BIT];

   // register writes and hardware updates
   always_comb begin
      in_sel_d   = in_sel_q;
      ref_d      = ref_q;
      rate_d     = rate_q;
      run_d      = run_q;
      pwr_d      = pwr_q;
      ch_d       = ch_q;
      cal_en_d   = cal_en_q;
      cal_pos_d  = cal_pos_q;
      cal_mag_d  = cal_mag_q;
      done_d     = done_q;
      wake_en_d  = wake_en_q;
      irq_en_d   = irq_en_q;
      res_byte_d = res_byte_q;
      res_hi_d   = res_hi_q;
      res_lo_d   = res_lo_q;
      wake_d     = 1'b0;
      if (ap_wr_q) begin
         case (ap_addr_q)
            OFS_INPUT_SELECT: in_sel_d = wbyte[SEL_PINS_HI:0];
            OFS_CONTROL: begin
               ref_d  = wbyte[CTL_REF_BIT];
               rate_d = rate_t'(wbyte[CTL_RATE_HI:CTL_RATE_LO]);
               pwr_d  = wbyte[CTL_PWR_BIT];
               if (!done_q && !run_q) begin
                  ch_d = wbyte[CTL_CH_HI:CTL_CH_LO];
               end
            end
            OFS_OFFSET_CAL: begin
               cal_en_d  = wbyte[CAL_EN_BIT];
               cal_pos_d = wbyte[CAL_POS_BIT];
               cal_mag_d = wbyte[CAL_MAG_HI:CAL_MAG_LO];
            end
            OFS_STATUS: begin
               if (!wbyte[ST_DONE_BIT]) begin
                  done_d = 1'b0;
               end
               wake_en_d = wbyte[ST_WAKE_BIT];
            end
            OFS_IRQ_MASK: irq_en_d = wbyte[MASK_IRQ_BIT];
            default: ;
         endcase
      end
      if (start) begin
         run_d = 1'b1;
      end
      if (abort) begin
         run_d = 1'b0;
      end
      // completion proceeds regardless of sleep; set beats clear
      if (eng_done) begin
         run_d      = 1'b0;
         done_d     = 1'b1;
         res_byte_d = corrected[11:4];
         res_hi_d   = {4'h0, corrected[11:8]};
         res_lo_d   = corrected[7:0];
         if (sleep_mode && wake_en_q && irq_en_q) begin
            wake_d = 1'b1;
         end
         if (sleep_mode && !irq_en_q) begin
            pwr_d = 1'b0;
         end
      end
   end

   // control register flops
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         in_sel_q   <= INPUT_SELECT_RESET;
         ref_q      <= 1'b0;
         rate_q     <= RATE_DIV16;
         run_q      <= 1'b0;
         pwr_q      <= 1'b0;
         ch_q       <= CHANNEL_RESET;
         cal_en_q   <= 1'b0;
         cal_pos_q  <= 1'b0;
         cal_mag_q  <= OFFSET_MAG_RESET;
         done_q     <= 1'b0;
         wake_en_q  <= 1'b0;
         irq_en_q   <= 1'b0;
         res_byte_q <= RESULT_RESET;
         res_hi_q   <= RESULT_RESET;
         res_lo_q   <= RESULT_RESET;
         wake_q     <= 1'b0;
      end else if (ce) begin
         in_sel_q   <= in_sel_d;
         ref_q      <= ref_d;
         rate_q     <= rate_d;
         run_q      <= run_d;
         pwr_q      <= pwr_d;
         ch_q       <= ch_d;
         cal_en_q   <= cal_en_d;
         cal_pos_q  <= cal_pos_d;
         cal_mag_q  <= cal_mag_d;
         done_q     <= done_d;
         wake_en_q  <= wake_en_d;
         irq_en_q   <= irq_en_d;
         res_byte_q <= res_byte_d;
         res_hi_q   <= res_hi_d;
         res_lo_q   <= res_lo_d;
         wake_q     <= wake_d;
      end
   end

   // ----------------------------------------------------------------
   // outputs to pins, analog front end and core
   // ----------------------------------------------------------------
   assign analog_pin_enable       = in_sel_q;
   assign reference_source_select = ref_q;
   assign pin_ref_function        = ref_q;
   assign pin_timer_function      = ~ref_q & timer_clock_select;
   assign pin_port_function       = ~ref_q & ~timer_clock_select;
   assign converter_power_on      = pwr_q;
   assign channel_select          = ch_q;
   assign conv_clock_rate         = rate_q;
   assign wake_request            = wake_q;
   assign irq_vector_jump         = wake_q & global_irq_enable;
   assign conversion_irq          = done_q & irq_en_q;
   assign irq_vector              = CONV_IRQ_VECTOR;
endmodule
`default_nettype wire

// file: logic/sar_adc_pkg.sv
package sar_adc_pkg;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS  = 40;
   localparam int unsigned BIT_TIME_NS    = 4000;
   localparam int unsigned BIT_CYCLES     = BIT_TIME_NS / CLK_PERIOD_NS;
   localparam logic [3:0]  SAMPLE_PERIODS = 4'h3;
   localparam int unsigned RESULT_W       = 12;
   localparam logic [3:0]  LAST_BIT       = 4'hb;

   // prescaler ratios
   localparam logic [6:0] DIV_BY_16 = 7'h10;
   localparam logic [6:0] DIV_BY_4  = 7'h04;
   localparam logic [6:0] DIV_BY_64 = 7'h40;

   // ----------------------------------------------------------------
   // register map (byte offsets)
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_INPUT_SELECT = 8'h00;
   localparam logic [7:0] OFS_CONTROL      = 8'h04;
   localparam logic [7:0] OFS_OFFSET_CAL   = 8'h08;
   localparam logic [7:0] OFS_RESULT_BYTE  = 8'h0c;
   localparam logic [7:0] OFS_RESULT_HIGH  = 8'h10;
   localparam logic [7:0] OFS_RESULT_LOW   = 8'h14;
   localparam logic [7:0] OFS_STATUS       = 8'h18;
   localparam logic [7:0] OFS_IRQ_MASK     = 8'h1c;

   // field positions
   localparam int unsigned CTL_REF_BIT   = 7;
   localparam int unsigned CTL_RATE_HI   = 6;
   localparam int unsigned CTL_RATE_LO   = 5;
   localparam int unsigned CTL_RUN_BIT   = 4;
   localparam int unsigned CTL_PWR_BIT   = 3;
   localparam int unsigned CTL_CH_HI     = 1;
   localparam int unsigned CTL_CH_LO     = 0;
   localparam int unsigned CAL_EN_BIT    = 7;
   localparam int unsigned CAL_POS_BIT   = 6;
   localparam int unsigned CAL_MAG_HI    = 5;
   localparam int unsigned CAL_MAG_LO    = 3;
   localparam int unsigned ST_DONE_BIT   = 5;
   localparam int unsigned ST_WAKE_BIT   = 3;
   localparam int unsigned MASK_IRQ_BIT  = 3;
   localparam int unsigned SEL_PINS_HI   = 3;

   // reset values
   localparam logic [3:0] INPUT_SELECT_RESET = 4'h0;
   localparam logic [1:0] CHANNEL_RESET      = 2'h0;
   localparam logic [2:0] OFFSET_MAG_RESET   = 3'h0;
   localparam logic [7:0] RESULT_RESET       = 8'h00;

   localparam logic [11:0] CONV_IRQ_VECTOR = 12'h00c;
   localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;
   localparam logic [2:0]  HSIZE_WORD      = 3'h2;

   typedef enum logic [1:0] {
      RATE_DIV16 = 2'b00,
      RATE_DIV4  = 2'b01,
      RATE_DIV64 = 2'b10,
      RATE_RING  = 2'b11
   } rate_t;

   typedef enum logic [1:0] {
      ST_IDLE    = 2'b00,
      ST_SAMPLE  = 2'b01,
      ST_CONVERT = 2'b10
   } sar_state_t;

endpackage

// file: logic/sar_engine.sv
`timescale 1ns/10ps
`default_nettype none
module sar_engine (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        ce,
   input  wire logic        start,
   input  wire logic        abort,
   input  wire logic        bit_tick,
   input  wire logic        comp_above,
   output logic             busy,
   output logic             sampling,
   output logic             done,
   output logic [11:0]      result,
   output logic [11:0]      dac_code
);
   import sar_adc_pkg::*;

   sar_state_t  state_q, state_d;
   logic [3:0]  step_q, step_d;
   logic [11:0] code_q, code_d;
   logic [11:0] result_q, result_d;
   logic        done_q, done_d;

   // ----------------------------------------------------------------
   // sample periods, then one decision per bit period, msb first
   // ----------------------------------------------------------------
   always_comb begin
      logic [11:0] kept;
      kept     = code_q;
      state_d  = state_q;
      step_d   = step_q;
      code_d   = code_q;
      result_d = result_q;
      done_d   = 1'b0;
      if (!comp_above) begin
         kept[step_q] = 1'b0;
      end
      case (state_q)
         ST_IDLE: begin
            if (start) begin
               state_d = ST_SAMPLE;
               step_d  = 4'h0;
               code_d  = '0;
            end
         end
         ST_SAMPLE: begin
            if (abort) begin
               state_d = ST_IDLE;
            end else if (bit_tick) begin
               if (step_q == SAMPLE_PERIODS - 4'h1) begin
                  state_d          = ST_CONVERT;
                  step_d           = LAST_BIT;
                  code_d           = '0;
                  code_d[LAST_BIT] = 1'b1;
               end else begin
                  step_d = step_q + 4'h1;
               end
            end
         end
         ST_CONVERT: begin
            if (abort) begin
               state_d = ST_IDLE;
            end else if (bit_tick) begin
               code_d = kept;
               if (step_q == 4'h0) begin
                  result_d = kept;
                  done_d   = 1'b1;
                  state_d  = ST_IDLE;
               end else begin
                  step_d             = step_q - 4'h1;
                  code_d[step_d]     = 1'b1;
               end
            end
         end
         default: state_d = ST_IDLE;
      endcase
   end

   // state registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_q  <= ST_IDLE;
         step_q   <= 4'h0;
         code_q   <= '0;
         result_q <= '0;
         done_q   <= 1'b0;
      end else if (ce) begin
         state_q  <= state_d;
         step_q   <= step_d;
         code_q   <= code_d;
         result_q <= result_d;
         done_q   <= done_d;
      end
   end

   assign busy     = (state_q != ST_IDLE);
   assign sampling = (state_q == ST_SAMPLE);
   assign done     = done_q;
   assign result   = result_q;
   assign dac_code = code_q;
endmodule
`default_nettype wire

// file: tb/adc_front_end.sv
`timescale 1ns/10ps
`default_nettype none
module adc_front_end #(parameter int HALF_NS = 1990) (
   input  wire logic [11:0] level,
   input  wire logic [11:0] dac_code,
   output logic             comparator_in,
   output logic             ring_osc_in
);
   // comparator high while the input sits at or above the trial code
   assign comparator_in = (level >= dac_code);
   // ring oscillator runs free, unrelated in phase to hclk
   initial begin
      ring_osc_in = 1'b0;
      forever #(HALF_NS) ring_osc_in = ~ring_osc_in;
   end
endmodule
`default_nettype wire

// file: tb/sar_adc_chk.sv
`timescale 1ns/10ps
`default_nettype none
module sar_adc_chk
   import sar_adc_pkg::*;
(
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hresp,
   input wire logic        reference_source_select,
   input wire logic        timer_clock_select,
   input wire logic        pin_ref_function,
   input wire logic        pin_timer_function,
   input wire logic        pin_port_function,
   input wire logic [11:0] irq_vector,
   input wire logic        irq_vector_jump,
   input wire logic        global_irq_enable,
   input wire logic        wake_request,
   input wire logic        sample_hold,
   input wire logic        converter_power_on,
   input wire logic [1:0]  channel_select
);
   // one clock domain for every property
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence s_held; sample_hold [*8]; endsequence
   property p_owner; pin_ref_function == reference_source_select && pin_timer_function
      == (!reference_source_select && timer_clock_select); endproperty
   a_owner: assert property (p_owner) else $error("shared pin owner wrong");
   property p_port; pin_port_function == !(pin_ref_function || pin_timer_function); endproperty
   a_port: assert property (p_port) else $error("port function wrong");
   property p_vec; irq_vector == CONV_IRQ_VECTOR; endproperty
   a_vec: assert property (p_vec) else $error("vector wrong");
   property p_jump; irq_vector_jump |-> wake_request && global_irq_enable; endproperty
   a_jump: assert property (p_jump) else $error("vector jump without cause");
   property p_pulse; wake_request |=> !wake_request; endproperty
   a_pulse: assert property (p_pulse) else $error("wake longer than a pulse");
   property p_power; $rose(sample_hold) |-> converter_power_on; endproperty
   a_power: assert property (p_power) else $error("sampling while powered off");
   property p_hold; $rose(sample_hold) |-> s_held; endproperty
   a_hold: assert property (p_hold) else $error("sample phase too short");
   property p_chan; sample_hold && $past(sample_hold) |-> $stable(channel_select); endproperty
   a_chan: assert property (p_chan) else $error("channel moved while busy");
   property p_resp; hresp == 1'b0; endproperty
   a_resp: assert property (p_resp) else $error("response not okay");
endmodule
`default_nettype wire

// file: tb/tb_sar_adc_control.sv
`timescale 1ns/10ps
`default_nettype none
module tb_sar_adc_control;
   import sar_adc_pkg::*;
   logic        hclk, hresetn, ce, hsel, hwrite, hready, hreadyout, hresp, sleep_mode;
   logic        global_irq_enable, timer_clock_select, ring_osc_in, comparator_in;
   logic        reference_source_select, pin_ref_function, pin_timer_function;
   logic        pin_port_function, converter_power_on, sample_hold, wake_request;
   logic        conversion_irq, irq_vector_jump;
   logic [1:0]  htrans, channel_select;
   logic [2:0]  hsize;
   logic [3:0]  analog_pin_enable;
   logic [11:0] dac_code, irq_vector, level;
   logic [31:0] haddr, hwdata, hrdata, q;
   rate_t       conv_clock_rate;
   int          error_cnt = 0, samples_checked = 0, jumps = 0;
   bit          irq_exp;
   assign hready = hreadyout;
   sar_adc_control dut (.*);
   adc_front_end fe (.*);
   // clock and vector jump counter
   initial begin
      hclk = 1'b0;
      forever #20 hclk = ~hclk;
   end
   always @(posedge hclk) if (irq_vector_jump === 1'b1) jumps <= jumps + 1;
   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic stuck(input bit hit);
      if (hit) begin
         error_cnt++;
         print_verdict;
      end
   endtask
   task automatic wait_rdy;
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 20);
      stuck(n >= 20);
   endtask
   // one single word transfer, read data into q
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel   <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      hwrite <= w;
      haddr  <= {24'h0, a};
      wait_rdy;
      htrans <= 2'h0;
      hsel   <= 1'b0;
      hwdata <= d;
      wait_rdy;
      q = hrdata;
      #1;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(q, e);
   endtask
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_regs;
      rdc(OFS_CONTROL, 32'h0);
      rdc(8'h40, 32'h0);
      bus(1'b1, OFS_INPUT_SELECT, 32'hff);
      rdc(OFS_INPUT_SELECT, 32'h0f);
      chk(analog_pin_enable, 4'hf);
      bus(1'b1, OFS_OFFSET_CAL, 32'hff);
      rdc(OFS_OFFSET_CAL, 32'hf8);
      timer_clock_select <= 1'b1;
      for (int r = 0; r < 4; r++) begin
         bus(1'b1, OFS_CONTROL, {24'h0, 1'b1, r[1:0], 5'h0});
         chk(conv_clock_rate, r[1:0]);
         chk({reference_source_select, pin_ref_function, pin_timer_function}, 3'h6);
      end
      bus(1'b1, OFS_CONTROL, 32'h0);
      chk(pin_timer_function, 1'b1);
      $display("register test done");
   endtask
   task automatic t_conv(input logic [1:0] r, input logic [7:0] c, input logic [11:0] lv,
                         input logic [11:0] e, input int lo, input int hi);
      int  n;
      time t0;
      level <= lv;
      bus(1'b1, OFS_OFFSET_CAL, {24'h0, c});
      repeat (200) @(posedge hclk); // acquisition and spacing
      bus(1'b1, OFS_CONTROL, {24'h0, 1'b0, r, 5'h19}); // channel 1
      t0 = $time;
      bus(1'b1, OFS_CONTROL, {24'h0, 1'b0, r, 5'h0a});
      chk(channel_select, 2'h1);
      rdc(OFS_CONTROL, {24'h0, 1'b0, r, 5'h19});
      n = 0;
      do begin
         bus(1'b0, OFS_CONTROL, 32'h0);
         n++;
      end while (q[CTL_RUN_BIT] !== 1'b0 && n < 2000);
      stuck(n >= 2000);
      n = int'(($time - t0) / 40);
      chk(n >= lo && n <= hi, 1'b1);
      rdc(OFS_RESULT_HIGH, {28'h0, e[11:8]});
      rdc(OFS_RESULT_LOW, {24'h0, e[7:0]});
      rdc(OFS_RESULT_BYTE, {24'h0, e[11:4]});
      bus(1'b0, OFS_STATUS, 32'h0);
      chk(q[ST_DONE_BIT], 1'b1);
      chk(conversion_irq, irq_exp);
      bus(1'b1, OFS_STATUS, 32'h0); // flag cleared before next start
      $display("conversion test done");
   endtask
   task automatic t_sleep;
      bus(1'b1, OFS_STATUS, 32'h08);
      bus(1'b1, OFS_IRQ_MASK, 32'h08);
      global_irq_enable <= 1'b1;
      sleep_mode        <= 1'b1;
      irq_exp = 1'b1;
      t_conv(2'h0, 8'h00, 12'h3c5, 12'h3c5, 1380, 1452);
      chk(jumps, 1);
      bus(1'b1, OFS_IRQ_MASK, 32'h0);
      irq_exp = 1'b0;
      t_conv(2'h0, 8'h00, 12'h0f0, 12'h0f0, 1380, 1452);
      chk({converter_power_on, jumps[3:0]}, 5'h01);
      sleep_mode <= 1'b0;
      $display("sleep test done");
   endtask
   // reset, then every scenario in turn
   initial begin
      hresetn            = 1'b0;
      ce                 = 1'b1;
      hsel               = 1'b0;
      htrans             = 2'h0;
      hwrite             = 1'b0;
      hsize              = HSIZE_WORD;
      haddr              = 32'h0;
      hwdata             = 32'h0;
      sleep_mode         = 1'b0;
      global_irq_enable  = 1'b0;
      timer_clock_select = 1'b0;
      level              = 12'h0;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      #1;
      chk(pin_port_function, 1'b1);
      t_regs;
      t_conv(2'h0, 8'h00, 12'h5a3, 12'h5a3, 1380, 1452);
      t_conv(2'h1, 8'hd8, 12'h100, 12'h106, 1440, 1512);
      t_conv(2'h2, 8'hb8, 12'h00a, 12'h000, 900, 972);
      t_conv(2'h3, 8'h78, 12'hfff, 12'hfff, 1380, 1520);
      t_sleep;
      print_verdict;
   end
endmodule
bind sar_adc_control sar_adc_chk chk (.*);
`default_nettype wire
